// *** ppc_port_pin_ctrl.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
`include "ppc_map.svh"
`default_nettype none
module ppc_port_pin_ctrl
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              timer0_overflow,
	input  wire logic              timer1_overflow,
	input  wire logic              sys_clk_out,
	input  wire logic [1:0]        port2_latch,
	input  wire logic              p0_7_latch,
	input  wire logic              p1_2_latch,
	input  wire logic [1:0]        port2_pin_in,
	output logic [1:0]             port2_pin_out,
	output logic [1:0]             port2_pin_oe_n,
	output logic [1:0]             port2_weak_pullup,
	output logic [1:0]             port2_input_schmitt,
	output ppc_pkg::ppc_mode_t     port2_mode_0,
	output ppc_pkg::ppc_mode_t     port2_mode_1,
	output logic [1:0]             port2_pin_value,
	output logic                   port2_schmitt_select,
	output logic                   port1_schmitt_select,
	output logic                   port0_schmitt_select,
	output logic                   p0_7_out,
	output logic                   p1_2_out,
	output logic                   crystal_output_pin
);
	import ppc_pkg::*;

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0]  port2_primary_mode_reg_ff;
	logic [1:0]  port2_secondary_mode_reg_ff;
	logic        t1_toggle_ff;
	logic        t0_toggle_ff;
	logic [1:0]  pin_in_meta_ff;
	logic [1:0]  pin_in_sync_ff;
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [11:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	logic        clock_out_enable;
	logic        timer1_toggle_out_enable;
	logic        timer0_toggle_out_enable;
	logic [1:0]  pin_mode_primary_bit;
	logic [1:0]  pin_mode_secondary_bit;
	logic        wr_fire;
	logic [31:0] nxt_rdata;
	logic [1:0]  nxt_rresp;

	localparam logic [9:0] primary_word   = 10'(`PPC_PRIMARY_IDX);
	localparam logic [9:0] secondary_word = 10'(`PPC_SECONDARY_IDX);

	assign port2_schmitt_select     = port2_primary_mode_reg_ff[`PPC_P2_SCHMITT_BIT];
	assign port1_schmitt_select     = port2_primary_mode_reg_ff[`PPC_P1_SCHMITT_BIT];
	assign port0_schmitt_select     = port2_primary_mode_reg_ff[`PPC_P0_SCHMITT_BIT];
	assign clock_out_enable         = port2_primary_mode_reg_ff[`PPC_CLKOUT_BIT];
	assign timer1_toggle_out_enable = port2_primary_mode_reg_ff[`PPC_T1_TOGGLE_BIT];
	assign timer0_toggle_out_enable = port2_primary_mode_reg_ff[`PPC_T0_TOGGLE_BIT];
	assign pin_mode_primary_bit     = port2_primary_mode_reg_ff[1:0];
	assign pin_mode_secondary_bit   = port2_secondary_mode_reg_ff;

	// ----------------------------------------------------------------
	// axi write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held_ff <= 1'b0;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held_ff <= 1'b0;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PPC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			if (aw_addr_ff[11:2] == primary_word
				|| aw_addr_ff[11:2] == secondary_word)
				bresp_ff <= `PPC_RESP_OKAY;
			else
				bresp_ff <= `PPC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// mode registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			port2_primary_mode_reg_ff <= `PPC_PRIMARY_RST;
		else if (wr_fire && w_strb_ff[0] && aw_addr_ff[11:2] == primary_word)
			port2_primary_mode_reg_ff <= w_data_ff[7:0];
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			port2_secondary_mode_reg_ff <= `PPC_SECONDARY_RST;
		else if (wr_fire && w_strb_ff[0] && aw_addr_ff[11:2] == secondary_word)
			port2_secondary_mode_reg_ff <= w_data_ff[1:0];
	end

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = `PPC_RESP_OKAY;
		if (s_axi_araddr[11:2] == primary_word)
			nxt_rdata = {24'h00_0000, port2_primary_mode_reg_ff};
		else if (s_axi_araddr[11:2] == secondary_word)
			nxt_rdata = {30'h0000_0000, port2_secondary_mode_reg_ff};
		else
			nxt_rresp = `PPC_RESP_SLVERR;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `PPC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
		else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// timer toggle outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			t1_toggle_ff <= 1'b0;
		else if (timer1_toggle_out_enable && timer1_overflow)
			t1_toggle_ff <= !t1_toggle_ff;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			t0_toggle_ff <= 1'b0;
		else if (timer0_toggle_out_enable && timer0_overflow)
			t0_toggle_ff <= !t0_toggle_ff;
	end

	assign p0_7_out = timer1_toggle_out_enable ? t1_toggle_ff : p0_7_latch;
	assign p1_2_out = timer0_toggle_out_enable ? t0_toggle_ff : p1_2_latch;
	assign crystal_output_pin = clock_out_enable & sys_clk_out;

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_in_meta_ff <= 2'h0;
			pin_in_sync_ff <= 2'h0;
		end
		else
		begin
			pin_in_meta_ff <= port2_pin_in;
			pin_in_sync_ff <= pin_in_meta_ff;
		end
	end

	assign port2_pin_value = pin_in_sync_ff;
	assign port2_mode_0 = ppc_mode_t'({pin_mode_primary_bit[0], pin_mode_secondary_bit[0]});
	assign port2_mode_1 = ppc_mode_t'({pin_mode_primary_bit[1], pin_mode_secondary_bit[1]});

	// ----------------------------------------------------------------
	// per-pin output drivers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			logic        drv_val;
			ppc_mode_t   mode;
			assign mode = ppc_mode_t'({pin_mode_primary_bit[gi], pin_mode_secondary_bit[gi]});
			if (gi == 0)
			begin : g_clk
				assign drv_val = clock_out_enable ? sys_clk_out : port2_latch[gi];
			end
			else
			begin : g_latch
				assign drv_val = port2_latch[gi];
			end
			always_comb
			begin
				port2_pin_out[gi]       = drv_val;
				port2_pin_oe_n[gi]      = 1'b1;
				port2_weak_pullup[gi]   = 1'b0;
				port2_input_schmitt[gi] = port2_schmitt_select;
				if (gi == 0 && clock_out_enable)
					port2_pin_oe_n[gi] = 1'b0;
				else
				begin
					case (mode)
						PPC_MODE_QUASI:
						begin
							port2_pin_oe_n[gi]    = drv_val;
							port2_weak_pullup[gi] = drv_val;
						end
						PPC_MODE_PUSH_PULL:
							port2_pin_oe_n[gi] = 1'b0;
						PPC_MODE_INPUT:
							port2_pin_oe_n[gi] = 1'b1;
						PPC_MODE_OPEN_DRN:
							port2_pin_oe_n[gi] = drv_val;
						default:
							port2_pin_oe_n[gi] = 1'b1;
					endcase
				end
			end
		end
	endgenerate
endmodule : ppc_port_pin_ctrl
`default_nettype wire

// *** ppc_map.svh ***
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// register byte addresses (printed offsets are not multiples of four, so index * 4)
`define PPC_PRIMARY_IDX     8'hB5
`define PPC_SECONDARY_IDX   8'hB6
`define PPC_PRIMARY_ADDR    12'h2D4
`define PPC_SECONDARY_ADDR  12'h2D8
// primary register field positions
`define PPC_P2_SCHMITT_BIT  7
`define PPC_P1_SCHMITT_BIT  6
`define PPC_P0_SCHMITT_BIT  5
`define PPC_CLKOUT_BIT      4
`define PPC_T1_TOGGLE_BIT   3
`define PPC_T0_TOGGLE_BIT   2
// reset values
`define PPC_PRIMARY_RST     8'h00
`define PPC_SECONDARY_RST   2'h0
// axi response codes
`define PPC_RESP_OKAY       2'h0
`define PPC_RESP_SLVERR     2'h2
`endif

// *** ppc_pkg.sv ***
`default_nettype none
package ppc_pkg;
	typedef enum logic [1:0]
	{
		PPC_MODE_QUASI     = 2'h0,
		PPC_MODE_PUSH_PULL = 2'h1,
		PPC_MODE_INPUT     = 2'h2,
		PPC_MODE_OPEN_DRN  = 2'h3
	} ppc_mode_t;
endpackage : ppc_pkg
`default_nettype wire

// *** ppc_port_pin_ctrl_assertions.sv ***
`default_nettype none
// ------------------------------
// pin control checker
// ------------------------------
module ppc_pin_ctrl_checker
(
	input wire logic               core_clk,
	input wire logic               rst,
	input wire logic               s_axi_bvalid,
	input wire logic               timer0_overflow,
	input wire logic               timer1_overflow,
	input wire logic               sys_clk_out,
	input wire logic [1:0]         port2_latch,
	input wire logic               p0_7_latch,
	input wire logic               p1_2_latch,
	input wire logic [1:0]         port2_pin_out,
	input wire logic [1:0]         port2_pin_oe_n,
	input wire logic [1:0]         port2_weak_pullup,
	input wire logic [1:0]         port2_input_schmitt,
	input wire ppc_pkg::ppc_mode_t port2_mode_1,
	input wire logic               port2_schmitt_select,
	input wire logic               p0_7_out,
	input wire logic               p1_2_out,
	input wire logic               crystal_output_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	import ppc_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_buf_select: assert property (port2_input_schmitt == {2{port2_schmitt_select}})
		else $error("input buffer select wrong");
	a_input_hiz: assert property (port2_mode_1 == PPC_MODE_INPUT |-> port2_pin_oe_n[1])
		else $error("input only pin driven");
	a_push_pull: assert property (port2_mode_1 == PPC_MODE_PUSH_PULL |->
		!port2_pin_oe_n[1] && port2_pin_out[1] == port2_latch[1])
		else $error("push pull drive wrong");
	a_open_drain: assert property (port2_mode_1 == PPC_MODE_OPEN_DRN |->
		port2_pin_oe_n[1] == port2_latch[1])
		else $error("open drain drive wrong");
	a_quasi_pull: assert property (port2_mode_1 == PPC_MODE_QUASI |->
		port2_weak_pullup[1] == port2_latch[1])
		else $error("quasi pullup wrong");
	a_clk_drive: assert property (crystal_output_pin |->
		sys_clk_out && !port2_pin_oe_n[0] && port2_pin_out[0])
		else $error("clock out not on pin");
	a_t1_toggle: assert property ($changed(p0_7_out) && $stable(p0_7_latch) &&
		!$rose(s_axi_bvalid) |-> $past(timer1_overflow))
		else $error("timer1 toggle without overflow");
	a_t0_toggle: assert property ($changed(p1_2_out) && $stable(p1_2_latch) &&
		!$rose(s_axi_bvalid) |-> $past(timer0_overflow))
		else $error("timer0 toggle without overflow");
	cover property (crystal_output_pin);
	cover property ($changed(p0_7_out) && $past(timer1_overflow));
	cover property (port2_mode_1 == PPC_MODE_OPEN_DRN);
endmodule : ppc_pin_ctrl_checker
bind ppc_port_pin_ctrl ppc_pin_ctrl_checker i_chk (.core_clk, .rst, .s_axi_bvalid,
	.timer0_overflow, .timer1_overflow, .sys_clk_out, .port2_latch, .p0_7_latch,
	.p1_2_latch, .port2_pin_out, .port2_pin_oe_n, .port2_weak_pullup,
	.port2_input_schmitt, .port2_mode_1, .port2_schmitt_select, .p0_7_out, .p1_2_out,
	.crystal_output_pin);
`default_nettype wire

// *** ppc_pin_partner.sv ***
`default_nettype none
// ------------------------------
// circuitry on port 2 pins
// ------------------------------
module ppc_pin_partner
(
	input wire logic       core_clk,
	input wire logic [1:0] dev_out,
	input wire logic [1:0] dev_oe_n,
	input wire logic [1:0] dev_pullup,
	input wire logic [1:0] ext_en,
	input wire logic [1:0] ext_val,
	output var logic [1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] float_ff = 2'h1;
	// undriven pin wanders each cycle
	always_ff @(posedge core_clk)
		float_ff <= ~float_ff;
	always_comb
		for (int i = 0; i < 2; i++)
			pin_level[i] = !dev_oe_n[i] ? dev_out[i] : ext_en[i] ? ext_val[i] :
				dev_pullup[i] ? 1'b1 : float_ff[i];
endmodule : ppc_pin_partner
`default_nettype wire

// *** ppc_port_pin_ctrl_tb_top.sv ***
`include "ppc_map.svh"
`default_nettype none
module ppc_port_pin_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ppc_pkg::*;
	logic core_clk = 0, rst = 1, sys_clk_out = 0, p0_7_latch = 0, p1_2_latch = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, timer0_overflow = 0, timer1_overflow = 0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] port2_latch = 2'h0, ext_en = 2'h0, ext_val = 2'h0, tg = 2'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic port2_schmitt_select, port1_schmitt_select, port0_schmitt_select;
	logic p0_7_out, p1_2_out, crystal_output_pin;
	logic [1:0] s_axi_bresp, s_axi_rresp, port2_pin_in, port2_pin_out, port2_pin_oe_n;
	logic [1:0] port2_weak_pullup, port2_input_schmitt, port2_pin_value;
	ppc_mode_t port2_mode_0, port2_mode_1;
	logic [33:0] bus_q[$];
	int fail_count = 0, comparisons = 0, cyc = 0;
	always #50 core_clk = ~core_clk;
	ppc_port_pin_ctrl i_dut (.*);
	ppc_pin_partner i_far (.core_clk, .dev_out(port2_pin_out), .dev_oe_n(port2_pin_oe_n),
		.dev_pullup(port2_weak_pullup), .ext_en, .ext_val, .pin_level(port2_pin_in));
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bus_q.push_back({r, 32'h0});
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'($urandom()), d};
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				s_axi_bready <= 1'b0;
		end
		while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		bus_q.push_back(e);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				s_axi_rready <= 1'b0;
		end
		while (s_axi_arvalid || s_axi_rready);
	endtask : rd
	always @(posedge core_clk)
	begin
		sys_clk_out <= ~sys_clk_out;
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", bus_q.pop_front(), {s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", bus_q.pop_front(), {s_axi_rresp, s_axi_rdata});
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			final_report();
		end
	end
	// ------------------------------
	// scenarios
	// ------------------------------
	initial
	begin
		void'($urandom(32'hE2D5));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd(`PPC_PRIMARY_ADDR, {`PPC_RESP_OKAY, 24'h0, `PPC_PRIMARY_RST});
		rd(`PPC_SECONDARY_ADDR, {`PPC_RESP_OKAY, 30'h0, `PPC_SECONDARY_RST});
		for (int i = 5; i < 8; i++)
		begin
			wr(`PPC_PRIMARY_ADDR, 8'h1 << i, 4'hF, `PPC_RESP_OKAY);
			@(negedge core_clk);
			chk("schmitt", 3'h1 << (i - 5), {port2_schmitt_select, port1_schmitt_select,
				port0_schmitt_select});
			chk("buffer", {2{i == 7}}, port2_input_schmitt);
		end
		$display("test schmitt done");
		for (int m = 0; m < 4; m++)
		begin
			wr(`PPC_PRIMARY_ADDR, {6'h0, {2{m[1]}}}, 4'hF, `PPC_RESP_OKAY);
			wr(`PPC_SECONDARY_ADDR, {6'($urandom()), {2{m[0]}}}, 4'hF, `PPC_RESP_OKAY);
			rd(`PPC_SECONDARY_ADDR, {`PPC_RESP_OKAY, 30'h0, {2{m[0]}}});
			port2_latch <= 2'($urandom());
			ext_val <= 2'($urandom());
			ext_en <= {2{m == 2}};
			repeat (3) @(posedge core_clk);
			@(negedge core_clk);
			chk("mode", {2{m[1:0]}}, {port2_mode_1, port2_mode_0});
			chk("oe_n", m == 1 ? 2'h0 : m == 2 ? 2'h3 : port2_latch, port2_pin_oe_n);
			chk("pullup", m == 0 ? port2_latch : 2'h0, port2_weak_pullup);
			chk("drive", port2_latch, port2_pin_out);
			if (m == 2)
				chk("pin", ext_val, port2_pin_value);
			else if (m < 2)
				chk("pin", port2_latch, port2_pin_value);
		end
		$display("test modes done");
		wr(`PPC_PRIMARY_ADDR, 8'h13, 4'hF, `PPC_RESP_OKAY);
		wr(`PPC_PRIMARY_ADDR, 8'h03, 4'h0, `PPC_RESP_OKAY);
		repeat (3)
		begin
			@(negedge core_clk);
			chk("clkout", {sys_clk_out, sys_clk_out, 1'b0},
				{crystal_output_pin, port2_pin_out[0], port2_pin_oe_n[0]});
		end
		wr(`PPC_PRIMARY_ADDR, 8'h0F, 4'hF, `PPC_RESP_OKAY);
		@(negedge core_clk);
		chk("latch", {1'b0, port2_latch[0]}, {crystal_output_pin, port2_pin_oe_n[0]});
		for (int k = 0; k < 6; k++)
		begin
			@(posedge core_clk);
			{timer1_overflow, timer0_overflow} <= 2'(k + 1);
			@(posedge core_clk);
			tg ^= {timer1_overflow, timer0_overflow};
			{timer1_overflow, timer0_overflow} <= 2'h0;
			@(negedge core_clk);
			chk("toggle", tg, {p0_7_out, p1_2_out});
		end
		@(posedge core_clk);
		{p0_7_latch, p1_2_latch} <= 2'h1;
		wr(`PPC_PRIMARY_ADDR, 8'h03, 4'hF, `PPC_RESP_OKAY);
		@(negedge core_clk);
		chk("revert", 2'h1, {p0_7_out, p1_2_out});
		@(posedge core_clk);
		{p0_7_latch, p1_2_latch} <= 2'h2;
		@(negedge core_clk);
		chk("latch follow", 2'h2, {p0_7_out, p1_2_out});
		$display("test outputs done");
		wr(12'h100, 8'hFF, 4'hF, `PPC_RESP_SLVERR);
		rd(12'h100, {`PPC_RESP_SLVERR, 32'h0});
		rd(`PPC_PRIMARY_ADDR, {`PPC_RESP_OKAY, 32'h3});
		$display("test unmapped done");
		final_report();
	end
endmodule : ppc_port_pin_ctrl_tb_top
`default_nettype wire
